/* File: spi_dev_end.sv */
`timescale 1ns/1ps
`include "spi_fr_defs.svh"
module spi_dev_end #(
  parameter logic [7:0] MAKER_CONT = 8'h11, // Arbitrary value
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [2:0] FAMILY     = 3'h2,  // Arbitrary value
  parameter logic [4:0] DENSITY    = 5'h03, // Arbitrary value
  parameter logic [1:0] SUB_CODE   = 2'h0,  // Arbitrary value
  parameter logic [2:0] REVISION   = 3'h1,  // Arbitrary value
  parameter int         WAKE_CYC   = `WAKE_REC_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  spi_link_if.dev                link,
  input  wire logic [63:0]       row_data_i,
  output logic                   row_rd_o,
  output logic [`ROW_W-1:0]      row_addr_o,
  output logic                   asleep_o
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    spi_fr_pkg::dev_state_t st;
    logic [1:0]             cs_s;
    logic [1:0]             sck_s;
    logic [1:0]             si_s;
    logic                   cs_d;
    logic                   sck_d;
    logic [2:0]             bit_n;
    logic [1:0]             byte_n;
    logic [7:0]             sh;
    logic [`ADDR_W-1:0]     addr;
    logic [63:0]            row;
    logic                   row_rd;
    logic [3:0]             id_n;
    logic [15:0]            wake_n;
    logic                   so;
    logic                   so_oe_n;
    logic                   asleep;
  } dev_reg_t;

  localparam dev_reg_t RESET_VAL = '{
    st:      spi_fr_pkg::D_IDLE,
    cs_s:    2'h3,
    sck_s:   2'h0,
    si_s:    2'h0,
    cs_d:    1'b1,
    sck_d:   1'b0,
    bit_n:   3'h0,
    byte_n:  2'h0,
    sh:      8'h00,
    addr:    18'h00000,
    row:     64'h0,
    row_rd:  1'b0,
    id_n:    4'h0,
    wake_n:  16'h0000,
    so:      1'b0,
    so_oe_n: 1'b1,
    asleep:  1'b0
  };

  localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYC - 1);
  localparam logic [15:0] PRODUCT   = {FAMILY, DENSITY, SUB_CODE, REVISION, 3'h0};

  dev_reg_t q;
  dev_reg_t d;

  // ==========================================================
  // Decoding
  // ==========================================================
  function automatic logic [7:0] id_byte(input logic [3:0] n);
    if (n < `ID_CONT_N) begin
      id_byte = MAKER_CONT;
    end else if (n == `ID_MAKER_IDX) begin
      id_byte = MAKER_CODE;
    end else if (n == `ID_PROD_HI) begin
      id_byte = PRODUCT[15:8];
    end else if (n == `ID_PROD_LO) begin
      id_byte = PRODUCT[7:0];
    end else begin
      id_byte = 8'h00;
    end
  endfunction : id_byte

  function automatic logic [7:0] row_byte(input logic [63:0] row, input logic [2:0] idx);
    row_byte = row[{idx, 3'h0} +: 8];
  endfunction : row_byte

  logic       cs_rise;
  logic       cs_fall;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] byte_in;
  logic       byte_end;
  logic [7:0] out_b;

  assign cs_rise  = q.cs_s[1] & ~q.cs_d;
  assign cs_fall  = ~q.cs_s[1] & q.cs_d;
  assign sck_rise = q.sck_s[1] & ~q.sck_d;
  assign sck_fall = ~q.sck_s[1] & q.sck_d;
  assign byte_in  = {q.sh[6:0], q.si_s[1]};
  assign byte_end = (q.bit_n == 3'h7);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    d        = q;
    d.cs_s   = {q.cs_s[0], link.cs_n};
    d.sck_s  = {q.sck_s[0], link.sck};
    d.si_s   = {q.si_s[0], link.si};
    d.cs_d   = q.cs_s[1];
    d.sck_d  = q.sck_s[1];
    d.row_rd = 1'b0;
    out_b    = 8'h00;
    // Row buffer loads in the cycle the read strobe is out
    if (q.row_rd) begin
      d.row = row_data_i;
    end
    if (cs_rise && q.st != spi_fr_pkg::D_WAKE) begin
      d.so_oe_n = 1'b1;
      d.bit_n   = 3'h0;
      d.byte_n  = 2'h0;
      if (q.st == spi_fr_pkg::D_ARM || q.st == spi_fr_pkg::D_SLEEP) begin
        d.st     = spi_fr_pkg::D_SLEEP;
        d.asleep = 1'b1;
      end else begin
        d.st = spi_fr_pkg::D_IDLE;
      end
    end else begin
      case (q.st)
        spi_fr_pkg::D_IDLE: begin
          if (cs_fall) begin
            d.st    = spi_fr_pkg::D_CMD;
            d.bit_n = 3'h0;
          end
        end
        spi_fr_pkg::D_CMD, spi_fr_pkg::D_ADDR, spi_fr_pkg::D_DUMMY: begin
          if (sck_rise) begin
            d.sh    = byte_in;
            d.bit_n = q.bit_n + 3'h1;
            if (byte_end) begin
              case (q.st)
                spi_fr_pkg::D_CMD: begin
                  d.byte_n = 2'h0;
                  d.id_n   = 4'h0;
                  if (byte_in == `OP_FAST_READ) begin
                    d.st = spi_fr_pkg::D_ADDR;
                  end else if (byte_in == `OP_ID_READ) begin
                    d.st = spi_fr_pkg::D_ID;
                  end else if (byte_in == `OP_SLEEP) begin
                    d.st = spi_fr_pkg::D_ARM;
                  end else begin
                    d.st = spi_fr_pkg::D_SKIP;
                  end
                end
                spi_fr_pkg::D_ADDR: begin
                  // Only the low bits of the last three bytes survive
                  d.addr   = {q.addr[9:0], byte_in};
                  d.byte_n = q.byte_n + 2'h1;
                  if (q.byte_n == 2'h2) begin
                    d.st = spi_fr_pkg::D_DUMMY;
                  end
                end
                default: begin
                  // Dummy byte done: fetch the first row
                  d.st     = spi_fr_pkg::D_DATA;
                  d.row_rd = 1'b1;
                end
              endcase
            end
          end
        end
        spi_fr_pkg::D_DATA, spi_fr_pkg::D_ID: begin
          // Input line is not looked at here
          if (sck_fall) begin
            if (q.bit_n == 3'h0) begin
              out_b = (q.st == spi_fr_pkg::D_DATA) ? row_byte(q.row, q.addr[2:0]) : id_byte(q.id_n);
            end else begin
              out_b = q.sh;
            end
            d.so      = out_b[7];
            d.so_oe_n = 1'b0;
            d.sh      = {out_b[6:0], 1'b0};
            d.bit_n   = q.bit_n + 3'h1;
            if (byte_end && q.st == spi_fr_pkg::D_DATA) begin
              d.addr = (q.addr == `ADDR_LAST) ? `ADDR_FIRST : q.addr + 18'h00001;
              if (q.addr[2:0] == 3'h7) begin
                d.row_rd = 1'b1;
              end
            end else if (byte_end && q.id_n != `ID_END) begin
              d.id_n = q.id_n + 4'h1;
            end
          end
        end
        spi_fr_pkg::D_SLEEP: begin
          // Clock and data input are never consulted here, only select edges
          d.so_oe_n = 1'b1;
          if (cs_fall) begin
            d.st     = spi_fr_pkg::D_WAKE;
            d.wake_n = 16'h0000;
          end
        end
        spi_fr_pkg::D_WAKE: begin
          d.so_oe_n = 1'b1;
          d.wake_n  = q.wake_n + 16'h0001;
          if (q.wake_n == WAKE_LAST) begin
            d.asleep = 1'b0;
            d.bit_n  = 3'h0;
            // A frame still open at the end is thrown away whole
            d.st     = q.cs_s[1] ? spi_fr_pkg::D_IDLE : spi_fr_pkg::D_SKIP;
          end
        end
        spi_fr_pkg::D_ARM, spi_fr_pkg::D_SKIP: begin
          d.st = q.st;
        end
        default: begin
          d.st = spi_fr_pkg::D_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign link.so      = q.so;
  assign link.so_oe_n = q.so_oe_n;
  assign row_rd_o     = q.row_rd;
  assign row_addr_o   = q.addr[`ADDR_W-1:3];
  assign asleep_o     = q.asleep;

endmodule : spi_dev_end

/* File: spi_fast_read_sleep_id_assertions.sv */
`timescale 1ns/1ps
module spi_fast_read_sleep_id_assertions #(
  parameter int HALF = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic so_line
);
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] rise;
    logic       sck;
  } mon_t;
  mon_t mon_q;
  mon_t mon_d;

  // ==========================================
  // Helper counters, rise count saturates on long reads
  always_comb begin
    mon_d     = mon_q;
    mon_d.sck = sck;
    mon_d.hi  = sck ? mon_q.hi + 8'h01 : 8'h00;
    if (cs_n)
      mon_d.rise = 8'h00;
    else if (sck && !mon_q.sck && mon_q.rise != 8'hff)
      mon_d.rise = mon_q.rise + 8'h01;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mon_q <= '0;
    end else begin
      mon_q <= mon_d;
    end
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_oe_start;
    $fell(so_oe_n) |-> !sck && !cs_n && (mon_q.rise == 8'h08 || mon_q.rise == 8'h28);
  endproperty
  property p_release;
    $rose(cs_n) |-> ##[1:6] so_oe_n;
  endproperty
  property p_idle_off;
    cs_n [*6] |-> so_oe_n;
  endproperty
  property p_hold_so;
    !so_oe_n && sck && $past(sck) |-> $stable(so);
  endproperty
  property p_sck_sel;
    sck |-> !cs_n;
  endproperty
  property p_si_hold;
    sck && $past(sck) |-> $stable(si);
  endproperty
  property p_sck_half;
    $fell(sck) |-> int'(mon_q.hi) == HALF;
  endproperty
  property p_cs_gap;
    $rose(cs_n) |-> (cs_n && !sck) [*8];
  endproperty

  a_oe_start : assert property (p_oe_start) else $error("output enabled at wrong clock count");
  a_release : assert property (p_release) else $error("output not released after deselect");
  a_idle_off : assert property (p_idle_off) else $error("output driven while deselected");
  a_hold_so : assert property (p_hold_so) else $error("data changed while clock high");
  a_sck_sel : assert property (p_sck_sel) else $error("clock high while deselected");
  a_si_hold : assert property (p_si_hold) else $error("input changed while clock high");
  a_sck_half : assert property (p_sck_half) else $error("clock high phase wrong length");
  a_cs_gap : assert property (p_cs_gap) else $error("select rise not followed by idle");

  c_read_data : cover property ($fell(so_oe_n) && mon_q.rise == 8'h28);
  c_id_data : cover property ($fell(so_oe_n) && mon_q.rise == 8'h08);
  c_read_end : cover property ($rose(cs_n) && !so_oe_n);
endmodule : spi_fast_read_sleep_id_assertions

/* File: spi_fr_defs.svh */
`ifndef SPI_FR_DEFS_SVH
`define SPI_FR_DEFS_SVH
`define OP_FAST_READ  8'h0b
`define OP_SLEEP      8'hb9
`define OP_ID_READ    8'h9f
`define ADDR_W        18
`define ROW_W         15
`define ADDR_LAST     18'h3ffff
`define ADDR_FIRST    18'h00000
`define ID_CONT_N     4'h6
`define ID_MAKER_IDX  4'h6
`define ID_PROD_HI    4'h7
`define ID_PROD_LO    4'h8
`define ID_END        4'h9
`define CLK_PERIOD_NS 4
`define WAKE_REC_NS   400
`define WAKE_REC_CYC  ((`WAKE_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCK_HALF      16
`define FR_TX_BITS    12'd40
`define ONE_TX_BITS   12'd8
`define ID_RX_BITS    12'd72
`endif

/* File: spi_fr_pkg.sv */
package spi_fr_pkg;
  typedef enum logic [3:0] {
    D_IDLE  = 4'h0,
    D_CMD   = 4'h1,
    D_ADDR  = 4'h2,
    D_DUMMY = 4'h3,
    D_DATA  = 4'h4,
    D_ID    = 4'h5,
    D_ARM   = 4'h6,
    D_SLEEP = 4'h7,
    D_WAKE  = 4'h8,
    D_SKIP  = 4'h9
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LOW  = 3'h1,
    H_HIGH = 3'h2,
    H_TAIL = 3'h3,
    H_REC  = 3'h4
  } host_state_t;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_ID    = 2'h1,
    OP_SLEEP = 2'h2,
    OP_WAKE  = 2'h3
  } host_op_t;
endpackage : spi_fr_pkg

/* File: spi_host_end.sv */
`timescale 1ns/1ps
`include "spi_fr_defs.svh"
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_reg_t;

  fifo_reg_t q;
  fifo_reg_t d;
  logic      full;
  logic      empty;

  assign full        = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign empty       = (q.wr == q.rd);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = q.mem[q.rd[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid_i && !full) begin
      d.mem[q.wr[AW-1:0]] = in_data_i;
      d.wr                = q.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : byte_fifo

module spi_host_end #(
  parameter int HALF     = `SCK_HALF,
  parameter int WAKE_CYC = `WAKE_REC_CYC,
  parameter int DEPTH    = 32
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  spi_link_if.host                  link,
  input  wire logic                 cmd_valid_i,
  output logic                      cmd_ready_o,
  input  wire spi_fr_pkg::host_op_t cmd_op_i,
  input  wire logic [`ADDR_W-1:0]   cmd_addr_i,
  input  wire logic [7:0]           cmd_len_i,
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  output logic [7:0]                rx_data_o
);
  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    spi_fr_pkg::host_state_t st;
    logic [15:0]             div;
    logic                    sck;
    logic                    cs_n;
    logic                    mosi;
    logic [39:0]             tx;
    logic [11:0]             bit_n;
    logic [11:0]             tx_bits;
    logic [11:0]             all_bits;
    logic [7:0]              rx;
    logic                    push;
    logic [1:0]              so_s;
    logic                    wake;
    logic                    rdy;
  } host_reg_t;

  localparam logic [15:0] HALF_LAST = 16'(HALF - 1);
  localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYC - 1);

  host_reg_t q;
  host_reg_t d;
  logic      fifo_ready;

  always_comb begin
    d      = q;
    d.so_s = {q.so_s[0], link.so_line};
    d.push = 1'b0;
    d.div  = q.div + 16'h0001;
    case (q.st)
      spi_fr_pkg::H_IDLE: begin
        d.div = 16'h0000;
        if (cmd_valid_i) begin
          d.bit_n = 12'h000;
          d.wake  = (cmd_op_i == spi_fr_pkg::OP_WAKE);
          case (cmd_op_i)
            spi_fr_pkg::OP_READ: begin
              d.tx       = {`OP_FAST_READ, 6'h00, cmd_addr_i, 8'h00};
              d.tx_bits  = `FR_TX_BITS;
              d.all_bits = `FR_TX_BITS + {1'b0, cmd_len_i, 3'h0};
            end
            spi_fr_pkg::OP_ID: begin
              d.tx       = {`OP_ID_READ, 32'h0};
              d.tx_bits  = `ONE_TX_BITS;
              d.all_bits = `ONE_TX_BITS + `ID_RX_BITS;
            end
            spi_fr_pkg::OP_SLEEP: begin
              d.tx       = {`OP_SLEEP, 32'h0};
              d.tx_bits  = `ONE_TX_BITS;
              d.all_bits = `ONE_TX_BITS;
            end
            default: begin
              // Throwaway select pulse only starts the wake
              d.tx       = 40'h0;
              d.tx_bits  = 12'h000;
              d.all_bits = 12'h000;
            end
          endcase
          d.cs_n = 1'b0;
          d.mosi = d.tx[39];
          d.st   = spi_fr_pkg::H_LOW;
        end
      end
      spi_fr_pkg::H_LOW: begin
        if (q.div == HALF_LAST) begin
          d.div = 16'h0000;
          if (q.bit_n == q.all_bits) begin
            // Whole opcode is in before select rises
            d.cs_n = 1'b1;
            d.st   = spi_fr_pkg::H_TAIL;
          end else if (q.bit_n >= q.tx_bits && q.bit_n[2:0] == 3'h0 && !fifo_ready) begin
            // Clock held until the buffer has room for a byte
            d.div = q.div;
          end else begin
            d.sck   = 1'b1;
            d.rx    = {q.rx[6:0], q.so_s[1]};
            d.bit_n = q.bit_n + 12'h001;
            d.push  = (q.bit_n >= q.tx_bits) && (q.bit_n[2:0] == 3'h7);
            d.st    = spi_fr_pkg::H_HIGH;
          end
        end
      end
      spi_fr_pkg::H_HIGH: begin
        if (q.div == HALF_LAST) begin
          d.div  = 16'h0000;
          d.sck  = 1'b0;
          // Filler toggles past the command so the target must ignore it
          d.tx   = {q.tx[38:0], q.bit_n[0]};
          d.mosi = q.tx[38];
          d.st   = spi_fr_pkg::H_LOW;
        end
      end
      spi_fr_pkg::H_TAIL: begin
        if (q.div == HALF_LAST) begin
          d.div = 16'h0000;
          d.st  = q.wake ? spi_fr_pkg::H_REC : spi_fr_pkg::H_IDLE;
        end
      end
      spi_fr_pkg::H_REC: begin
        // Nothing is sent until recovery has run out
        if (q.div == WAKE_LAST) begin
          d.st = spi_fr_pkg::H_IDLE;
        end
      end
      default: begin
        d.st = spi_fr_pkg::H_IDLE;
      end
    endcase
    d.rdy = (d.st == spi_fr_pkg::H_IDLE);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{st: spi_fr_pkg::H_IDLE, cs_n: 1'b1, so_s: 2'h3, rdy: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .in_valid_i (q.push),
    .in_ready_o (fifo_ready),
    .in_data_i  (q.rx),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o (rx_data_o)
  );

  assign link.cs_n  = q.cs_n;
  assign link.sck   = q.sck;
  assign link.si    = q.mosi;
  assign cmd_ready_o = q.rdy;
endmodule : spi_host_end

/* File: spi_link_if.sv */
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe_n;
  logic so_line;

  // Released output reads high, as with a pull-up
  assign so_line = so_oe_n ? 1'b1 : so;

  modport dev (
    input  cs_n,
    input  sck,
    input  si,
    output so,
    output so_oe_n
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input  so_line
  );
endinterface : spi_link_if

/* File: test_spi_fast_read_sleep_id.sv */
`timescale 1ns/1ps
module test_spi_fast_read_sleep_id;
  localparam int         HALF     = 8;
  localparam int         WAKE     = 4;
  localparam int         LIMIT    = 40000;
  localparam logic [7:0] ID_CONT  = 8'h11; // Arbitrary value
  localparam logic [7:0] ID_MAKER = 8'h5a; // Arbitrary value
  localparam logic [2:0] ID_FAM   = 3'h2;  // Arbitrary value
  localparam logic [4:0] ID_DEN   = 5'h03; // Arbitrary value
  localparam logic [1:0] ID_SUB   = 2'h0;  // Arbitrary value
  localparam logic [2:0] ID_REV   = 3'h1;  // Arbitrary value

  logic                 clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic [63:0]          row_data;
  logic                 row_rd;
  logic [14:0]          row_addr;
  logic                 asleep;
  logic                 cmd_valid = 1'b0;
  logic                 cmd_ready;
  spi_fr_pkg::host_op_t cmd_op = spi_fr_pkg::OP_READ;
  logic [17:0]          cmd_addr = 18'h00000;
  logic [7:0]           cmd_len = 8'h00;
  logic                 rx_valid;
  logic                 rx_ready = 1'b1;
  logic [7:0]           rx_data;
  int                   failures = 0;
  int                   n_tests = 0;
  int                   cyc = 0;
  int                   oe_low = 0;
  int                   sck_rises = 0;
  logic                 sleep_cs = 1'b0;
  logic                 asleep_q = 1'b0;
  logic                 sck_q = 1'b0;
  logic [14:0]          rows[$];

  always #2 clk_i = ~clk_i;

  spi_link_if spi_link_if_i ();
  spi_dev_end #(.MAKER_CONT(ID_CONT), .MAKER_CODE(ID_MAKER), .FAMILY(ID_FAM), .DENSITY(ID_DEN),
    .SUB_CODE(ID_SUB), .REVISION(ID_REV), .WAKE_CYC(WAKE)) spi_dev_end_i (.clk_i(clk_i),
    .reset_i(reset_i), .link(spi_link_if_i.dev), .row_data_i(row_data), .row_rd_o(row_rd),
    .row_addr_o(row_addr), .asleep_o(asleep));
  spi_host_end #(.HALF(HALF), .WAKE_CYC(WAKE), .DEPTH(32)) spi_host_end_i (.clk_i(clk_i),
    .reset_i(reset_i), .link(spi_link_if_i.host), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .rx_data_o(rx_data));
  spi_fast_read_sleep_id_assertions #(.HALF(HALF)) spi_fast_read_sleep_id_assertions_i (
    .clk_i(clk_i), .reset_i(reset_i), .cs_n(spi_link_if_i.cs_n), .sck(spi_link_if_i.sck),
    .si(spi_link_if_i.si), .so(spi_link_if_i.so), .so_oe_n(spi_link_if_i.so_oe_n),
    .so_line(spi_link_if_i.so_line));

  // ==========================================
  // Array model, content derived from the byte index
  function automatic logic [7:0] bdat(input logic [17:0] a);
    return a[7:0] ^ {a[17:12], 2'h1};
  endfunction : bdat

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      row_data[8*k +: 8] = bdat({row_addr, k[2:0]});
    end
  end

  // ==========================================
  // Monitors, sampled at the falling edge where all is settled
  always @(negedge clk_i) begin
    cyc++;
    if (row_rd === 1'b1) rows.push_back(row_addr);
    if (spi_link_if_i.so_oe_n === 1'b0) oe_low++;
    if (asleep === 1'b1 && asleep_q !== 1'b1) sleep_cs = spi_link_if_i.cs_n;
    asleep_q = asleep;
    if (spi_link_if_i.sck === 1'b1 && sck_q !== 1'b1) sck_rises++;
    sck_q = spi_link_if_i.sck;
    if (cyc == LIMIT) begin
      failures++;
      test_done();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk

  task automatic send(input spi_fr_pkg::host_op_t op, input logic [17:0] addr, input logic [7:0] len);
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= addr;
    cmd_len   <= len;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
  endtask : send

  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(negedge clk_i);
      t++;
    end while (cmd_ready !== 1'b1 && t < 20000);
    chk("cmd_ready", 1, cmd_ready);
  endtask : wait_ready

  task automatic pop(input logic [7:0] exp);
    int t;
    t = 0;
    do begin
      @(negedge clk_i);
      t++;
    end while (rx_valid !== 1'b1 && t < 5000);
    chk("rx_valid", 1, rx_valid);
    chk("rx_data", exp, rx_data);
    @(posedge clk_i);
  endtask : pop

  // ==========================================
  // Scenarios
  task automatic t_read(input logic [17:0] addr, input int len, input bit fill);
    int n0;
    int s0;
    logic [17:0] a;
    logic [14:0] exp_rows[$];
    rows.delete();
    s0 = sck_rises;
    if (fill) @(posedge clk_i) rx_ready <= 1'b0;
    send(spi_fr_pkg::OP_READ, addr, len[7:0]);
    if (fill) begin
      n0 = -1;
      for (int t = 0; t < 200 && n0 != sck_rises; t++) begin
        n0 = sck_rises;
        repeat (4 * HALF) @(negedge clk_i);
      end
      chk("stall_rises", 40 + 32 * 8, sck_rises - s0);
      chk("stall_cs_n", 0, spi_link_if_i.cs_n);
      @(posedge clk_i) rx_ready <= 1'b1;
    end
    for (int i = 0; i < len; i++) begin
      a = addr + 18'(i);
      pop(bdat(a));
      if (i == 0 || a[2:0] == 3'h0) exp_rows.push_back(a[17:3]);
    end
    wait_ready();
    chk("row_count", exp_rows.size(), rows.size());
    for (int i = 0; i < exp_rows.size() && i < rows.size(); i++) chk("row_addr", exp_rows[i], rows[i]);
  endtask : t_read

  task automatic t_id();
    send(spi_fr_pkg::OP_ID, 18'h00000, 8'h00);
    for (int i = 0; i < 6; i++) pop(ID_CONT);
    pop(ID_MAKER);
    pop({ID_FAM, ID_DEN});
    pop({ID_SUB, ID_REV, 3'h0});
    wait_ready();
  endtask : t_id

  task automatic t_sleep_wake();
    sleep_cs = 1'b0;
    send(spi_fr_pkg::OP_SLEEP, 18'h00000, 8'h00);
    wait_ready();
    chk("sleep_cs_n", 1, sleep_cs);
    chk("asleep", 1, asleep);
    chk("so_oe_n", 1, spi_link_if_i.so_oe_n);
    oe_low = 0;
    send(spi_fr_pkg::OP_WAKE, 18'h00000, 8'h00);
    wait_ready();
    chk("wake_oe_low", 0, oe_low);
    chk("asleep", 0, asleep);
    t_id();
  endtask : t_sleep_wake

  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk("cs_n", 1, spi_link_if_i.cs_n);
    chk("so_oe_n", 1, spi_link_if_i.so_oe_n);
    chk("cmd_ready", 1, cmd_ready);
    t_read(18'h3fff0, 36, 1'b1);
    t_read(18'h1235a, 2, 1'b0);
    t_read(18'h2a5c5, 1, 1'b0);
    t_id();
    t_sleep_wake();
    test_done();
  end
endmodule : test_spi_fast_read_sleep_id
